// file: inc/hook_regs_pkg.sv
// Behaviour
// [R1] Slot 16 reports ring-side negative transistor current, signed, 195.3 nA per bit.
// [R2] Slot 15 reports ring-side positive transistor current, signed, 3.097 uA per bit.
// [R3] Slot 19 reports tip-side main transistor current, signed, 3.097 uA per bit.
// [R4] Slot 17 reports tip-side negative transistor current, signed, 195.3 nA per bit.
// [R5] Slot 14 reports tip-side positive transistor current, signed, 3.097 uA per bit.
// [R6] Slot 24 sets the hook debounce interval at 1.25 ms per count.
// [R7] Bits 15 to 3 of slot 25 give the hook low-pass filter coefficient.
// [R8] Slot 26 sets the hook mask interval at 1.25 us per count.
// [R9] Every slot of the bank holds zero after reset.
// [R10] Measurements refresh their slots and override software; coefficient bits 2:0 ignored.
`default_nettype none
package hook_regs_pkg;

  // Register indices as printed; byte address is four times the index.
  localparam int NUM_SLOTS = 9;
  localparam int NUM_MEAS  = 5;
  localparam logic [5:0] IDX_TIP_POS   = 6'h0E;
  localparam logic [5:0] IDX_RING_POS  = 6'h0F;
  localparam logic [5:0] IDX_RING_NEG  = 6'h10;
  localparam logic [5:0] IDX_TIP_NEG   = 6'h11;
  localparam logic [5:0] IDX_TIP_MAIN  = 6'h13;
  localparam logic [5:0] IDX_DEBOUNCE  = 6'h18;
  localparam logic [5:0] IDX_FILTER    = 6'h19;
  localparam logic [5:0] IDX_MASK      = 6'h1A;
  localparam logic [5:0] IDX_STATUS    = 6'h1B;

  // Slot order inside the bank; the first five are measurement slots.
  localparam logic [5:0] SLOT_INDEX [NUM_SLOTS] = '{
    IDX_TIP_POS, IDX_RING_POS, IDX_RING_NEG, IDX_TIP_NEG, IDX_TIP_MAIN,
    IDX_DEBOUNCE, IDX_FILTER, IDX_MASK, IDX_STATUS};
  localparam logic [3:0] SLOT_DEBOUNCE = 4'h5;
  localparam logic [3:0] SLOT_FILTER   = 4'h6;
  localparam logic [3:0] SLOT_MASK     = 4'h7;
  localparam logic [3:0] SLOT_STATUS   = 4'h8;

  localparam logic [15:0] REG_RESET   = 16'h0000;
  localparam logic [15:0] FILTER_KEEP = 16'hFFF8;
  localparam int          FILTER_LSB  = 3;
  localparam int          STAT_HOOK   = 0;
  localparam int          STAT_MASKED = 1;
  localparam int          STAT_DEB    = 2;

  // Timing of the interval counters.
  localparam int CLK_PERIOD_NS     = 50;
  localparam int DEB_LSB_NS        = 1250000;
  localparam int MASK_LSB_NS       = 1250;
  localparam int DEB_TICK_CYCLES   = DEB_LSB_NS / CLK_PERIOD_NS;
  localparam int MASK_TICK_CYCLES  = MASK_LSB_NS / CLK_PERIOD_NS;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Measurement path into the bank; one strobe per measurement slot.
  typedef struct packed {
    logic [NUM_MEAS-1:0]       valid;
    logic [NUM_MEAS-1:0][15:0] value;
  } cur_meas_t;

  // Settings handed to the loop closure detector.
  typedef struct packed {
    logic [15:0] debounce;
    logic [12:0] coeff;
    logic [15:0] mask;
  } hook_cfg_t;

endpackage : hook_regs_pkg
`default_nettype wire

// file: logic/interval_timer.sv
`default_nettype none
module interval_timer (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic        tick,
  input  wire logic [15:0] interval,
  output logic             busy,
  output logic             done
);

  logic [15:0] left_r;

  // Loads the interval, counts ticks down and flags the end for one cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      left_r <= 16'h0000;
      busy   <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (start) begin
        left_r <= interval;
        busy   <= 1'b1;
      end else if (busy && left_r == 16'h0000) begin
        busy <= 1'b0;
        done <= 1'b1;
      end else if (busy && tick) begin
        left_r <= left_r - 16'h0001;
      end
    end
  end

endmodule : interval_timer
`default_nettype wire

// file: logic/hook_regs.sv
// The AXI4-Lite register port was chosen for this implementation.
`default_nettype none
module hook_regs
  import hook_regs_pkg::*;
#(
  parameter int DEB_TICK = DEB_TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Measurement path and detector side.
  input  wire cur_meas_t   meas,
  input  wire logic        hook_raw,
  input  wire logic        mask_start,
  output hook_cfg_t        cfg,
  output logic             hook_state,
  output logic             hook_masked
);

  // Returns the slot number of a byte address, or NUM_SLOTS when unmapped.
  function automatic logic [3:0] slot_of(input logic [7:0] addr);
    logic [3:0] s;
    s = 4'(NUM_SLOTS);
    if (addr[1:0] == 2'b00) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        if (addr[7:2] == SLOT_INDEX[i]) begin
          s = 4'(i);
        end
      end
    end
    return s;
  endfunction : slot_of

  logic [15:0] bank_r [NUM_SLOTS-1];
  logic [7:0]  aw_addr_r;
  logic        aw_held_r;
  logic [15:0] w_data_r;
  logic [1:0]  w_strb_r;
  logic        w_held_r;
  logic        do_write;
  logic [3:0]  wr_slot;
  logic [3:0]  rd_slot;
  logic [15:0] wr_merge;
  logic [15:0] status_word;
  logic [15:0] deb_div_r;
  logic [4:0]  mask_div_r;
  logic        deb_tick;
  logic        mask_tick;
  logic        mismatch;
  logic        deb_busy;
  logic        deb_done;
  logic        mask_done;

  // Address and data channels are taken independently and held until the write.
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready  = !w_held_r;
  assign do_write      = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_slot       = slot_of(aw_addr_r);

  // Captures the write address.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_addr_r <= 8'h00;
      aw_held_r <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_addr_r <= s_axi_awaddr;
      aw_held_r <= 1'b1;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  // Captures the write data and the two byte strobes that reach the register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      w_data_r <= 16'h0000;
      w_strb_r <= 2'b00;
      w_held_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_data_r <= s_axi_wdata[15:0];
      w_strb_r <= s_axi_wstrb[1:0];
      w_held_r <= 1'b1;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  // Write response; unmapped or read-only slots answer with an error.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_slot >= SLOT_STATUS) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Byte lanes merged over the current content of the addressed slot.
  always_comb begin
    wr_merge = 16'h0000;
    if (wr_slot < SLOT_STATUS) begin
      wr_merge = bank_r[wr_slot[2:0]];
    end
    if (w_strb_r[0]) begin
      wr_merge[7:0] = w_data_r[7:0];
    end
    if (w_strb_r[1]) begin
      wr_merge[15:8] = w_data_r[15:8];
    end
  end

  // One storage word per slot except the status slot; measurement strobes take priority over software.
  // Only the measurement slots get a strobe branch, so no strobe is indexed past
  // the width of the measurement path.
  generate
    for (genvar g = 0; g < NUM_SLOTS - 1; g++) begin : g_slot
      if (g < NUM_MEAS) begin : g_meas
        always_ff @(posedge clk or negedge reset_n) begin
          if (!reset_n) begin
            bank_r[g] <= REG_RESET; // [R9]
          end else if (meas.valid[g]) begin
            bank_r[g] <= meas.value[g]; // [R1] [R2] [R3] [R4] [R5] [R10]
          end else if (do_write && wr_slot == 4'(g)) begin
            bank_r[g] <= wr_merge;
          end
        end
      end else begin : g_cfg
        always_ff @(posedge clk or negedge reset_n) begin
          if (!reset_n) begin
            bank_r[g] <= REG_RESET; // [R9]
          end else if (do_write && wr_slot == 4'(g)) begin
            if (4'(g) == SLOT_FILTER) begin
              bank_r[g] <= wr_merge & FILTER_KEEP; // [R10]
            end else begin
              bank_r[g] <= wr_merge;
            end
          end
        end
      end
    end
  endgenerate

  // Status word shows the detector's own state.
  always_comb begin
    status_word              = 16'h0000;
    status_word[STAT_HOOK]   = hook_state;
    status_word[STAT_MASKED] = hook_masked;
    status_word[STAT_DEB]    = deb_busy;
  end

  assign rd_slot       = slot_of(s_axi_araddr);
  assign s_axi_arready = !s_axi_rvalid;

  // Read channel; the answer is registered one cycle after the address.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      if (rd_slot == SLOT_STATUS) begin
        s_axi_rdata <= {16'h0000, status_word};
      end else if (rd_slot < SLOT_STATUS) begin
        s_axi_rdata <= {16'h0000, bank_r[rd_slot[2:0]]};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Settings handed to the detector.
  assign cfg.debounce = bank_r[SLOT_DEBOUNCE[2:0]]; // [R6]
  assign cfg.coeff    = bank_r[SLOT_FILTER[2:0]][15:FILTER_LSB]; // [R7]
  assign cfg.mask     = bank_r[SLOT_MASK[2:0]]; // [R8]

  // Divider giving one enable per debounce count.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      deb_div_r <= 16'h0000;
    end else if (deb_tick) begin
      deb_div_r <= 16'h0000;
    end else begin
      deb_div_r <= deb_div_r + 16'h0001;
    end
  end
  assign deb_tick = (deb_div_r == 16'(DEB_TICK - 1)); // [R6]

  // Divider giving one enable per mask count.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_div_r <= 5'h00;
    end else if (mask_tick) begin
      mask_div_r <= 5'h00;
    end else begin
      mask_div_r <= mask_div_r + 5'h01;
    end
  end
  assign mask_tick = (mask_div_r == 5'(MASK_TICK_CYCLES - 1)); // [R8]

  // Mask window: detector input is ignored while it runs.
  interval_timer u_mask (
    .clk      (clk),
    .reset_n  (reset_n),
    .start    (mask_start),
    .abort    (1'b0),
    .tick     (mask_tick),
    .interval (cfg.mask),
    .busy     (hook_masked),
    .done     (mask_done)
  ); // [R8]

  assign mismatch = (hook_raw != hook_state) && !hook_masked;

  // Debounce window: aborted whenever the raw level falls back, started again on the next change.
  interval_timer u_deb (
    .clk      (clk),
    .reset_n  (reset_n),
    .start    (mismatch && !deb_busy && !deb_done),
    .abort    (!mismatch && deb_busy),
    .tick     (deb_tick),
    .interval (cfg.debounce),
    .busy     (deb_busy),
    .done     (deb_done)
  ); // [R6]

  // Hook state flips only when the change outlasted the debounce window.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hook_state <= 1'b0;
    end else if (deb_done && mismatch) begin
      hook_state <= hook_raw; // [R6]
    end
  end

endmodule : hook_regs
`default_nettype wire

// file: tb/hook_regs_properties.sv
`default_nettype none
module hook_regs_checker
  import hook_regs_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        mask_start,
  input wire hook_cfg_t   cfg,
  input wire logic        hook_masked
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  wa_r;
  logic [15:0] wd_r;
  logic [1:0]  ws_r;
  logic [7:0]  ra_r;
  logic        rd_map;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Remembers the last accepted write address, write data and read address.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wa_r <= 8'h00;
      wd_r <= 16'h0000;
      ws_r <= 2'h0;
      ra_r <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[15:0];
      if (s_axi_wvalid && s_axi_wready) ws_r <= s_axi_wstrb[1:0];
      if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
    end
  end
  // Aligned read addresses that name a slot of the bank.
  assign rd_map = ra_r[1:0] == 2'h0 && ra_r[7:2] inside {SLOT_INDEX};
  AST_CFG_RESET: assert property ($rose(reset_n) |-> cfg == '0)
    else $error("cfg not zero after reset");
  AST_DEB_WR: assert property ($rose(s_axi_bvalid) && wa_r == 8'h60 && ws_r == 2'h3 |->
    cfg.debounce == wd_r) else $error("debounce not written");
  AST_COEFF_WR: assert property ($rose(s_axi_bvalid) && wa_r == 8'h64 && ws_r == 2'h3 |->
    cfg.coeff == wd_r[15:3]) else $error("coefficient not written");
  AST_MASK_WR: assert property ($rose(s_axi_bvalid) && wa_r == 8'h68 && ws_r == 2'h3 |->
    cfg.mask == wd_r) else $error("mask interval not written");
  AST_FILTER_RD: assert property (s_axi_rvalid && ra_r == 8'h64 |->
    s_axi_rdata[2:0] == 3'h0) else $error("filter low bits not zero");
  AST_UNMAP_RD: assert property (s_axi_rvalid && !rd_map |-> s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
  AST_MASK_START: assert property (mask_start |=> hook_masked)
    else $error("mask window did not start");
  AST_MASK_LEN: assert property (mask_start && cfg.mask == 16'h0002 |=>
    hook_masked [*8] ##[1:60] !hook_masked) else $error("mask window length wrong");
  cover property (s_axi_rvalid && !rd_map);
  cover property ($fell(hook_masked));
  cover property ($rose(s_axi_bvalid) && wa_r == 8'h64);
endmodule : hook_regs_checker
bind hook_regs hook_regs_checker u_chk (
  .clk           (clk),
  .reset_n       (reset_n),
  .s_axi_awaddr  (s_axi_awaddr),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wdata   (s_axi_wdata),
  .s_axi_wstrb   (s_axi_wstrb),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_araddr  (s_axi_araddr),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rresp   (s_axi_rresp),
  .s_axi_rvalid  (s_axi_rvalid),
  .mask_start    (mask_start),
  .cfg           (cfg),
  .hook_masked   (hook_masked)
);
`default_nettype wire

// file: tb/hook_regs_test.sv
`default_nettype none
module hook_regs_test
  import hook_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1, hook_raw = 1'b0, mask_start = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        hook_state, hook_masked;
  cur_meas_t   meas = '0;
  hook_cfg_t   cfg;
  logic [33:0] exp_q[$];
  logic [15:0] v;
  int          error_cnt = 0, n_compared = 0, seed = 4, n;
  hook_regs #(.DEB_TICK(20)) DUT (
    .clk           (clk),
    .reset_n       (reset_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .meas          (meas),
    .hook_raw      (hook_raw),
    .mask_start    (mask_start),
    .cfg           (cfg),
    .hook_state    (hook_state),
    .hook_masked   (hook_masked)
  );
  // Free-running 20 MHz clock.
  initial begin
    forever #25 clk = ~clk;
  end
  // Prints the verdict and stops the run.
  task automatic print_verdict;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  // Compares one bus answer with the oldest expectation.
  task automatic check(input logic [33:0] got);
    logic [33:0] e;
    e = exp_q.pop_front();
    n_compared++;
    if (got !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, e);
    end
  endtask : check
  // Watches the response channels.
  always @(posedge clk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready) check({s_axi_bresp, 32'h0});
    if (s_axi_rvalid === 1'b1 && s_axi_rready) check({s_axi_rresp, s_axi_rdata});
  end
  // Checks the count of a bounded wait; reaching the limit ends the run.
  task automatic await_resp(input int k, input int lim);
    if (k >= lim) begin
      error_cnt++;
      print_verdict();
    end
  endtask : await_resp
  // One write cycle; address and data offered together, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] s,
                    input logic [1:0] r);
    int k;
    k = 0;
    exp_q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= {2'h0, s};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 50);
    await_resp(k, 50);
  endtask : wr
  // One read cycle with its expected response and data.
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int k;
    k = 0;
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 50);
    await_resp(k, 50);
  endtask : rd
  // Main sequence.
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) rd({SLOT_INDEX[i], 2'h0}, {RESP_OKAY, 32'h0});
    for (int i = 0; i < 8; i++) begin
      v = 16'($random(seed));
      wr({SLOT_INDEX[i], 2'h0}, v, 2'h3, RESP_OKAY);
      rd({SLOT_INDEX[i], 2'h0}, {RESP_OKAY, 16'h0, (i == 6) ? v & FILTER_KEEP : v});
    end
    v = 16'($random(seed));
    wr(8'h60, 16'hA5C3, 2'h3, RESP_OKAY);
    wr(8'h60, v, 2'h1, RESP_OKAY);
    wr(8'h60, v, 2'h0, RESP_OKAY);
    rd(8'h60, {RESP_OKAY, 16'h0, 8'hA5, v[7:0]});
    for (int i = 0; i < 5; i++) begin
      v = 16'($random(seed));
      meas.value[i] <= v;
      meas.valid[i] <= 1'b1;
      @(posedge clk);
      meas.valid[i] <= 1'b0;
      rd({SLOT_INDEX[i], 2'h0}, {RESP_OKAY, 16'h0, v});
    end
    wr(8'h00, 16'h1234, 2'h3, RESP_SLVERR);
    rd(8'h48, {RESP_SLVERR, 32'h0});
    wr(8'h68, 16'h0002, 2'h3, RESP_OKAY);
    mask_start <= 1'b1;
    @(posedge clk);
    mask_start <= 1'b0;
    rd(8'h6C, {RESP_OKAY, 32'h2});
    @(posedge clk);
    for (n = 0; n < 200 && hook_masked !== 1'b0; n++) @(posedge clk);
    await_resp(n, 200);
    rd(8'h6C, {RESP_OKAY, 32'h0});
    wr(8'h60, 16'h0001, 2'h3, RESP_OKAY);
    hook_raw <= 1'b1;
    for (n = 0; n < 500 && hook_state !== 1'b1; n++) @(posedge clk);
    await_resp(n, 500);
    rd(8'h6C, {RESP_OKAY, 32'h1});
    print_verdict();
  end
endmodule : hook_regs_test
`default_nettype wire
